// ---- verilog/sccs_top.sv ----
/*
 Strap configuration loader and core clock selector.
 Assumes straps and clock pin are asynchronous; supply monitors are async levels.
 Core clock sys_clk samples the external clock pin, so that pin must be well below
 half the core rate.
*/
`timescale 1ns/10ps
module sccs_top
	import sccs_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = WDOG_CYCLES	// Watchdog span in core cycles
) (
	input  wire logic       sys_clk,	// Core clock
	input  wire logic       rst,	// Power-on reset, active high
	input  wire logic       analog_supply_uv,	// Analog supply undervoltage
	input  wire logic       five_volt_regulator_output_uv,	// Regulator undervoltage
	input  wire logic       io_supply_uv,	// I/O supply undervoltage
	input  wire logic       mode_select,	// Low selects standalone
	input  wire logic [6:0] strap_pins,	// strap_pin_6 .. strap_pin_0
	input  wire logic       clk_pin,	// External clock pin
	output logic            standalone_r,	// Standalone mode active
	output logic            serial_enable_r,	// Serial and single wire enabled
	output logic [3:0]      microstep_resolution_code_r,	// Microstep code
	output logic [4:0]      run_current_scale_r,	// Run current
	output logic [4:0]      hold_current_scale_r,	// Hold current
	output logic [3:0]      off_time_setting_r,	// Chopper off time
	output logic            quiet_chopper_enable_r,	// Quiet chopper bit
	output logic            ext_clk_select_r,	// Core timing on external clock
	output logic            config_reset_r	// Defaults being loaded
);
	//*************************************************************************
	// Reset merge and synchronisation
	//*************************************************************************
	logic       uv_any;	// Any monitored supply low
	logic       uv_sync;	// Undervoltage, synchronised
	logic       mode_sync;	// Mode pin, synchronised
	logic [6:0] strap_sync;	// Straps, synchronised
	logic       clk_sync;	// Clock pin, synchronised
	logic       clk_prev_r;	// Clock pin last cycle
	logic       load_pend_r;	// Apply straps at next cycle
	logic       clk_rise;	// Rising edge on clock pin

	// Core supply is not monitored, only these three
	assign uv_any = analog_supply_uv | five_volt_regulator_output_uv | io_supply_uv;	// see RULE_08

	sccs_sync3 #(.WIDTH(10)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({uv_any, mode_select, strap_pins, clk_pin}),
		.sync_out ({uv_sync, mode_sync, strap_sync, clk_sync})
	);

	// Reset and undervoltage both hold defaults
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			config_reset_r <= 1'b1;
		end else begin
			config_reset_r <= uv_sync;	// see RULE_08
		end
	end

	// Straps captured one cycle after defaults release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			load_pend_r <= 1'b1;
		end else if (uv_sync) begin
			load_pend_r <= 1'b1;
		end else if (!config_reset_r) begin
			load_pend_r <= 1'b0;
		end
	end

	//*************************************************************************
	// Strap decode
	//*************************************************************************
	// Microstep code from two straps
	function automatic logic [3:0] sccs_microstep_resolution_code(input logic [1:0] s);
		unique case (s)
			2'h0: sccs_microstep_resolution_code = MICROSTEP_RESOLUTION_CODE_8;
			2'h1: sccs_microstep_resolution_code = MICROSTEP_RESOLUTION_CODE_16;
			2'h2: sccs_microstep_resolution_code = MICROSTEP_RESOLUTION_CODE_32;
			2'h3: sccs_microstep_resolution_code = MICROSTEP_RESOLUTION_CODE_64;
		endcase
	endfunction

	// Run current from three straps, top code saturates at 31
	function automatic logic [4:0] sccs_run_current_scale(input logic [2:0] n);
		if (n == 3'h7) begin
			sccs_run_current_scale = RUN_CURRENT_SCALE_TOP;
		end else begin
			sccs_run_current_scale = RUN_CURRENT_SCALE_BASE + {1'b0, n, 1'b0};
		end
	endfunction

	logic [4:0] run_current_scale_dec;	// Decoded run current
	assign run_current_scale_dec = sccs_run_current_scale(strap_sync[STRAP_RUN_CURRENT_SCALE_LSB +: 3]);	// see RULE_03

	// Mode and configuration registers; loaded only at release so live strap
	// changes do not disturb a running motor
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			standalone_r                <= 1'b0;
			serial_enable_r             <= 1'b1;
			microstep_resolution_code_r <= MICROSTEP_RESOLUTION_CODE_RESET;
			run_current_scale_r         <= RUN_CURRENT_SCALE_RESET;
			hold_current_scale_r        <= HOLD_CURRENT_SCALE_RESET;
			off_time_setting_r          <= OFF_TIME_SETTING_RESET;
			quiet_chopper_enable_r      <= 1'b0;
		end else if (config_reset_r) begin
			standalone_r                <= 1'b0;	// see RULE_08
			serial_enable_r             <= 1'b1;
			microstep_resolution_code_r <= MICROSTEP_RESOLUTION_CODE_RESET;
			run_current_scale_r         <= RUN_CURRENT_SCALE_RESET;
			hold_current_scale_r        <= HOLD_CURRENT_SCALE_RESET;
			off_time_setting_r          <= OFF_TIME_SETTING_RESET;
			quiet_chopper_enable_r      <= 1'b0;
		end else if (load_pend_r) begin
			// Mode pin low means standalone, serial off
			standalone_r    <= !mode_sync;	// see RULE_01, RULE_16
			serial_enable_r <= mode_sync;	// see RULE_01
			if (!mode_sync) begin
				microstep_resolution_code_r <= sccs_microstep_resolution_code(strap_sync[STRAP_MICROSTEP_RESOLUTION_CODE_LSB +: 2]);	// see RULE_02
				run_current_scale_r         <= run_current_scale_dec;	// see RULE_03
				// Hold equals run, or half of it
				if (strap_sync[STRAP_HOLD_BIT]) begin
					hold_current_scale_r <= {1'b0, run_current_scale_dec[4:1]};	// see RULE_05
				end else begin
					hold_current_scale_r <= run_current_scale_dec;	// see RULE_05
				end
				// Hysteresis chopper vs quiet chopper
				if (strap_sync[STRAP_CHOP_BIT]) begin
					quiet_chopper_enable_r <= 1'b1;	// see RULE_04
				end else begin
					off_time_setting_r <= OFF_TIME_SETTING_STANDALONE;	// see RULE_04
				end
			end
		end
	end

	//*************************************************************************
	// Clock selection and watchdog
	//*************************************************************************
	sccs_clk_state_t clk_state_r;	// Selector state
	logic [15:0]     wdog_r;	// Cycles since last clock edge

	// Edge detect on filtered pin, never on the first stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk_prev_r <= 1'b0;
		end else begin
			clk_prev_r <= clk_sync;
		end
	end
	assign clk_rise = clk_sync & ~clk_prev_r;

	// Idle counter; saturates so it never wraps back under the limit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdog_r <= 16'h0000;
		end else if (clk_rise) begin
			wdog_r <= 16'h0000;
		end else if (wdog_r != 16'hFFFF) begin
			wdog_r <= wdog_r + 16'h0001;
		end
	end

	// Internal by default; armed on first edge, external on second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk_state_r <= SCCS_CLK_INT;
		end else if (config_reset_r) begin
			clk_state_r <= SCCS_CLK_INT;	// see RULE_11
		end else begin
			unique case (clk_state_r)
				SCCS_CLK_INT: if (clk_rise) begin
					clk_state_r <= SCCS_CLK_ARM;
				end
				SCCS_CLK_ARM: if (clk_rise) begin
					clk_state_r <= SCCS_CLK_EXT;	// see RULE_12
				end else if (wdog_r > 16'(WDOG_LIMIT)) begin
					clk_state_r <= SCCS_CLK_INT;
				end
				SCCS_CLK_EXT: if (!clk_rise && wdog_r > 16'(WDOG_LIMIT)) begin
					clk_state_r <= SCCS_CLK_INT;	// see RULE_13
				end
				default: clk_state_r <= SCCS_CLK_INT;
			endcase
		end
	end

	// Registered select output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_clk_select_r <= 1'b0;
		end else begin
			ext_clk_select_r <= (clk_state_r == SCCS_CLK_EXT);	// see RULE_11
		end
	end

	//*************************************************************************
	// Checks
	//*************************************************************************
	property p_serial_off;
		@(posedge sys_clk) disable iff (rst) standalone_r |-> !serial_enable_r;
	endproperty
	a_serial_off: assert property (p_serial_off) else $error("serial on in standalone");	// see RULE_01

	property p_microstep_resolution_code_range;
		@(posedge sys_clk) disable iff (rst)
			standalone_r |-> (microstep_resolution_code_r >= MICROSTEP_RESOLUTION_CODE_64 && microstep_resolution_code_r <= MICROSTEP_RESOLUTION_CODE_8);
	endproperty
	a_microstep_resolution_code_range: assert property (p_microstep_resolution_code_range) else $error("bad microstep code");	// see RULE_02

	property p_run_current_scale_even;
		@(posedge sys_clk) disable iff (rst)
			standalone_r |-> (run_current_scale_r == RUN_CURRENT_SCALE_TOP || run_current_scale_r[0] == 1'b0);
	endproperty
	a_run_current_scale_even: assert property (p_run_current_scale_even) else $error("bad run current");	// see RULE_03

	property p_chop_mode;
		@(posedge sys_clk) disable iff (rst)
			standalone_r |-> (quiet_chopper_enable_r != (off_time_setting_r == OFF_TIME_SETTING_STANDALONE));
	endproperty
	a_chop_mode: assert property (p_chop_mode) else $error("chopper selection wrong");	// see RULE_04

	property p_hold;
		@(posedge sys_clk) disable iff (rst)
			standalone_r |-> (hold_current_scale_r == run_current_scale_r ||
				hold_current_scale_r == {1'b0, run_current_scale_r[4:1]});
	endproperty
	a_hold: assert property (p_hold) else $error("hold current wrong");	// see RULE_05

	property p_uv_default;
		@(posedge sys_clk) disable iff (rst) uv_sync |=> ##1 !standalone_r ##1 !ext_clk_select_r;
	endproperty
	a_uv_default: assert property (p_uv_default) else $error("defaults not reloaded");	// see RULE_08

	property p_ext_second;
		@(posedge sys_clk) disable iff (rst) $rose(ext_clk_select_r) |-> $past(clk_rise, 2);
	endproperty
	a_ext_second: assert property (p_ext_second) else $error("switch without edge");	// see RULE_12

	property p_wdog;
		@(posedge sys_clk) disable iff (rst)
			(ext_clk_select_r && wdog_r > 16'(WDOG_LIMIT) && !clk_rise && !config_reset_r) |-> ##2 !ext_clk_select_r;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog failed");	// see RULE_13

	property p_load;
		@(posedge sys_clk) disable iff (rst)
			$fell(config_reset_r) |=> ##1 (standalone_r == !$past(mode_sync, 2));
	endproperty
	a_load: assert property (p_load) else $error("straps not applied");	// see RULE_16
endmodule

// ---- verilog/sccs_pkg.sv ----
/*
 Constants for the strap configuration and clock select block.
 Assumes a single core clock sys_clk at 125 MHz and an active high async reset.
*/
//*****************************************************************************
// Overview of operation
// (RULE_01) Mode pin low: standalone, serial interfaces off
// (RULE_02) Straps 1..0 pick microstep code 5..2
// (RULE_03) Straps 4..2 give run current 16+2n, 7->31
// (RULE_04) Strap 5 low: off time 3, high: quiet
// (RULE_05) Strap 6 high halves hold current
// (RULE_06) Controller enables diagnostics before standalone
// (RULE_07) Controller rests motor 100 ms before quiet
// (RULE_08) Defaults on power-on and any supply undervoltage; the core supply is not monitored, only the analog, regulator and I/O supplies
// (RULE_09) Controller disables driver, reinitialises after reboot
// (RULE_10) Controller pulls I/O supply low with inputs low
// (RULE_11) Clock input low: internal oscillator used
// (RULE_12) External clock after second rising edge
// (RULE_13) Watchdog falls back after 32 idle cycles
// (RULE_14) External clock 10 to 16 MHz
// (RULE_15) Suggested serial start-up datagram order
// (RULE_16) Straps synchronised and applied at reset release
//*****************************************************************************
package sccs_pkg;
	// Core clock rate in kHz
	localparam int unsigned SYS_CLK_KHZ        = 125000;
	// Internal oscillator figure in kHz, used to scale the watchdog
	localparam int unsigned INT_OSC_KHZ        = 12000;
	// Watchdog span in internal oscillator cycles
	localparam int unsigned WDOG_OSC_CYCLES    = 32;
	// Same span in core cycles, rounded down
	localparam int unsigned WDOG_CYCLES        = (WDOG_OSC_CYCLES * SYS_CLK_KHZ) / INT_OSC_KHZ;
	// Rising edges needed before the external clock takes over
	localparam logic [1:0]  EXT_EDGES_NEEDED   = 2'h2;
	// Default values after reset
	localparam logic [3:0]  MICROSTEP_RESOLUTION_CODE_RESET         = 4'h0;
	localparam logic [4:0]  RUN_CURRENT_SCALE_RESET         = 5'h1F;
	localparam logic [4:0]  HOLD_CURRENT_SCALE_RESET        = 5'h10;
	localparam logic [3:0]  OFF_TIME_SETTING_RESET         = 4'h0;
	// Standalone decode values
	localparam logic [3:0]  MICROSTEP_RESOLUTION_CODE_8             = 4'h5;
	localparam logic [3:0]  MICROSTEP_RESOLUTION_CODE_16            = 4'h4;
	localparam logic [3:0]  MICROSTEP_RESOLUTION_CODE_32            = 4'h3;
	localparam logic [3:0]  MICROSTEP_RESOLUTION_CODE_64            = 4'h2;
	localparam logic [4:0]  RUN_CURRENT_SCALE_BASE          = 5'h10;
	localparam logic [4:0]  RUN_CURRENT_SCALE_TOP           = 5'h1F;
	localparam logic [3:0]  OFF_TIME_SETTING_STANDALONE    = 4'h3;
	// Strap field positions on the strap bus
	localparam int unsigned STRAP_MICROSTEP_RESOLUTION_CODE_LSB     = 0;
	localparam int unsigned STRAP_RUN_CURRENT_SCALE_LSB     = 2;
	localparam int unsigned STRAP_CHOP_BIT     = 5;
	localparam int unsigned STRAP_HOLD_BIT     = 6;
	// Clock selector states
	typedef enum logic [1:0] {SCCS_CLK_INT, SCCS_CLK_ARM, SCCS_CLK_EXT} sccs_clk_state_t;
endpackage

// ---- verilog/sccs_sync3.sv ----
/*
 Three stage synchroniser with agreement filter.
 Assumes an asynchronous input; output changes when stages two and three agree.
*/
`timescale 1ns/10ps
module sccs_sync3 #(
	parameter int unsigned WIDTH = 1	// Number of bits
) (
	input  wire logic             sys_clk,	// Core clock
	input  wire logic             rst,	// Async reset
	input  wire logic [WIDTH-1:0] async_in,	// Pin level
	output logic      [WIDTH-1:0] sync_out	// Filtered level
);
	logic [WIDTH-1:0] s1_r;	// First stage, read only by s2
	logic [WIDTH-1:0] s2_r;	// Second stage
	logic [WIDTH-1:0] s3_r;	// Third stage
	wire  logic [WIDTH-1:0] sync_nxt;	// Filter next value
	genvar g;

	// Shift chain, kept out of reset so it fills from the pins while reset
	// is held; the straps are then settled when reset lifts
	always_ff @(posedge sys_clk) begin
		s1_r <= async_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// Per bit agreement filter, holds on disagreement to reject glitches
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign sync_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : sync_out[g];
		end
	endgenerate

	// Filter output register, one driver for the whole vector
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync_out <= '0;
		end else begin
			sync_out <= sync_nxt;
		end
	end
endmodule

// ---- verification/sccs_ext_clk_src.sv ----
/*
 Partner model: external clock source of the motion controller.
 Assumes the bench gates it through run; the pin rests low while off.
*/
`timescale 1ns/10ps
module sccs_ext_clk_src #(
	parameter int unsigned HALF_NS = 40	// Half period, 12.5 MHz
) (
	input  wire logic run,	// Source enabled
	output logic      clk_pin	// Clock pin level
);
	// Pin held low while stopped, so the core stays internal
	// Toggles inside the 10 to 16 MHz band with 50 percent duty
	// Period is ten core cycles, so edges always land on a falling edge of sys_clk
	initial begin
		clk_pin = 1'b0;
		forever begin
			#(HALF_NS);
			clk_pin = run ? ~clk_pin : 1'b0;
		end
	end
endmodule

// ---- verification/strap_config_clock_select_tb.sv ----
/*
 Self-checking bench for the strap loader and clock selector.
 Assumes sccs_top, sccs_pkg and the clock source model are compiled first.
*/
`timescale 1ns/10ps
module strap_config_clock_select_tb;
	import sccs_pkg::*;
	//****************************************************************
	// Signals
	//****************************************************************
	localparam int unsigned WDOG = 20;	// Shortened watchdog span
	logic       sys_clk     = 1'b0;	// Core clock
	logic       rst         = 1'b1;	// Power-on reset
	logic       uv_a        = 1'b0;	// Analog supply low
	logic       uv_r        = 1'b0;	// Regulator low
	logic       uv_io       = 1'b0;	// I/O supply low
	logic       mode_select = 1'b0;	// Low is standalone
	logic       run         = 1'b0;	// External clock on
	logic [6:0] strap_pins  = 7'h00;	// Strap levels
	wire logic  clk_pin;	// External clock pin
	logic       sa_o, ser_o, q_o, ext_o, cr_o;	// Flag outputs
	logic [3:0] microstep_resolution_code_o, off_time_setting_o;	// Code outputs
	logic [4:0] run_current_scale_o, hold_o;	// Current outputs
	int         n_mismatch  = 0;	// Failed compares
	int         comparisons = 0;	// All compares
	int         cycles      = 0;	// Timeout counter
	logic [6:0] s;	// Strap value under test

	sccs_top #(.WDOG_LIMIT(WDOG)) DUT (.sys_clk(sys_clk), .rst(rst), .analog_supply_uv(uv_a),
		.five_volt_regulator_output_uv(uv_r), .io_supply_uv(uv_io), .mode_select(mode_select),
		.strap_pins(strap_pins), .clk_pin(clk_pin), .standalone_r(sa_o), .serial_enable_r(ser_o),
		.microstep_resolution_code_r(microstep_resolution_code_o), .run_current_scale_r(run_current_scale_o),
		.hold_current_scale_r(hold_o), .off_time_setting_r(off_time_setting_o), .quiet_chopper_enable_r(q_o),
		.ext_clk_select_r(ext_o), .config_reset_r(cr_o));
	sccs_ext_clk_src u_clk_src (.run(run), .clk_pin(clk_pin));

	//****************************************************************
	// Clock, timeout and shared tasks
	//****************************************************************
	// Core clock at 125 MHz
	always #4 sys_clk = ~sys_clk;
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	// Verdict and end of run
	task final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Case-equal compare, so an unknown never matches
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// Cycles, then the fixed 1 ns drive offset
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Reset with straps steady, since they are only taken at release
	// Each mid-run reset reapplies every setting, as after a reboot
	task reset_with(input logic m, input logic [6:0] v);
		rst = 1'b1;
		mode_select = m;
		strap_pins = v;
		cyc(10);
		check("config_reset in reset", 8'(cr_o), 8'h01);
		rst = 1'b0;
		cyc(10);
	endtask
	// Reference model of the whole configuration from mode and straps
	task check_cfg(input logic m, input logic [6:0] v, input logic dflt);
		int sa, microstep_resolution_code, run_current_scale, hold, off_time_setting, q;
		sa = (!m && !dflt) ? 1 : 0;
		microstep_resolution_code = MICROSTEP_RESOLUTION_CODE_RESET;
		run_current_scale = RUN_CURRENT_SCALE_RESET;
		hold = HOLD_CURRENT_SCALE_RESET;
		off_time_setting = OFF_TIME_SETTING_RESET;
		q = 0;
		// Standalone decode
		if (sa == 1) begin
			microstep_resolution_code = 5 - v[1:0];
			run_current_scale = (v[4:2] == 3'h7) ? 31 : 16 + 2 * v[4:2];
			hold = v[6] ? run_current_scale / 2 : run_current_scale;
			off_time_setting = v[5] ? OFF_TIME_SETTING_RESET : 3;
			q = v[5];
		end
		check("config_reset", 8'(cr_o), 8'(dflt));
		check("standalone", 8'(sa_o), 8'(sa));
		check("serial_enable", 8'(ser_o), 8'(!sa));
		check("microstep_resolution_code", 8'(microstep_resolution_code_o), 8'(microstep_resolution_code));
		check("run_current_scale", 8'(run_current_scale_o), 8'(run_current_scale));
		check("off_time_setting", 8'(off_time_setting_o), 8'(off_time_setting));
		check("quiet", 8'(q_o), 8'(q));
		check("hold", 8'(hold_o), 8'(hold));
	endtask

	//****************************************************************
	// Main sequence
	//****************************************************************
	initial begin
		void'($urandom(96246));
		// Every strap code, then a live change that must be ignored
		for (int i = 0; i < 128; i++) begin
			reset_with(1'b0, 7'(i));
			check_cfg(1'b0, 7'(i), 1'b0);
			strap_pins = 7'($urandom());
			cyc(8);
			check_cfg(1'b0, 7'(i), 1'b0);
		end
		$display("test straps done");
		// Mode high keeps defaults and the serial path
		// Diagnostics stay unconfigured, nothing here reads them
		// Serial start-up datagrams are left to the serial path
		reset_with(1'b1, 7'h7F);
		check_cfg(1'b1, 7'h7F, 1'b0);
		$display("test mode done");
		// Each monitored supply forces defaults, release reloads straps
		for (int k = 0; k < 3; k++) begin
			s = 7'($urandom());
			reset_with(1'b0, s);
			{uv_a, uv_r, uv_io} = 3'(4 >> k);
			cyc(8);
			check_cfg(1'b0, s, 1'b1);
			{uv_a, uv_r, uv_io} = 3'h0;
			cyc(10);
			check_cfg(1'b0, s, 1'b0);
		end
		$display("test undervoltage done");
		// Hardware reset: I/O supply pulled low with every input low
		{mode_select, strap_pins, run} = 9'h000;
		uv_io = 1'b1;
		cyc(8);
		check_cfg(1'b0, 7'h00, 1'b1);
		uv_io = 1'b0;
		cyc(10);
		check_cfg(1'b0, 7'h00, 1'b0);
		$display("test hardware reset done");
		// No step pulses are issued, so the motor always rests
		// Clock pin low keeps the internal oscillator
		check("ext idle", 8'(ext_o), 8'h00);
		// Two rounds: takeover on second rise, fallback when the clock stops
		for (int r = 0; r < 2; r++) begin
			run = 1'b1;
			@(posedge clk_pin);
			cyc(9);
			check("ext after one rise", 8'(ext_o), 8'h00);
			@(posedge clk_pin);
			cyc(9);
			check("ext after two rises", 8'(ext_o), 8'h01);
			cyc(WDOG + 10);
			check("ext while running", 8'(ext_o), 8'h01);
			run = 1'b0;
			cyc(WDOG + 16);
			check("ext after stop", 8'(ext_o), 8'h00);
		end
		$display("test clock select done");
		final_report();
	end
endmodule
